// ==== dma_pkg.sv ====
// constants and types shared by the data memory access block
// Function
// - lowest addresses: 32 register file, 64 standard I/O, 416 extended I/O, 8192 SRAM
// - extended I/O reachable only by load/store, never by short I/O instructions
// - external SRAM starts right above internal SRAM, up to the 64K top
// - addresses above internal memory go transparently to external SRAM
// - read and write strobes stay inactive during internal accesses
// - external accesses happen only while external SRAM enable is set
// - without wait-states an external byte costs one extra cycle
// - return address on external stack costs three extra cycles
// - one, two, three wait-states add two, three, four cycles per byte
// - external stack with wait-states costs five, seven or nine extra cycles
// - displacement mode adds unsigned offset up to 63 to Y or Z
// - pre-decrement before, post-increment after forming the address
// - internal SRAM access completes in two clock cycles
// - 4 Kbyte nonvolatile byte space through address, data, control registers
// - nonvolatile read halts the CPU four cycles
// - nonvolatile write halts the CPU two cycles, then programs in background
// - nonvolatile byte write lasts 26,368 oscillator cycles, about 3.3ms
// - write strobe bit stays set while a write runs, clears when done
// - a reset during a nonvolatile write still lets the write complete
// - low address valid when latch enable falls; latch enable low during data
package dma_pkg;
  localparam int REGFILE_SIZE = 32;
  localparam int STD_IO_SIZE = 64;
  localparam int EXT_IO_SIZE = 416;
  localparam int INT_SRAM_SIZE = 8192;
  localparam logic [15:0] STD_IO_BASE = 16'(REGFILE_SIZE);
  localparam logic [15:0] EXT_IO_BASE = 16'(REGFILE_SIZE + STD_IO_SIZE);
  localparam logic [15:0] INT_SRAM_BASE = 16'(REGFILE_SIZE + STD_IO_SIZE + EXT_IO_SIZE);
  localparam logic [15:0] EXT_SRAM_BASE = 16'(REGFILE_SIZE + STD_IO_SIZE + EXT_IO_SIZE
                                              + INT_SRAM_SIZE);
  localparam logic [15:0] IO_SHORT_OFFSET = 16'h0020;
  localparam int EXT_BYTE_EXTRA = 1;
  localparam int RET_EXTRA_BASE = 3;
  localparam int RET_EXTRA_PER_WS = 2;
  localparam int NVM_ADDR_W = 12;
  localparam int NVM_DEPTH = 4096;
  localparam logic [2:0] NVM_READ_HALT = 3'h4;
  localparam logic [2:0] NVM_WRITE_HALT = 3'h2;
  localparam logic [2:0] NVM_MASTER_WINDOW = 3'h4;
  localparam int NVM_WRITE_RC_DEFAULT = 26368;
  localparam int NVM_WRITE_TYP_US = 3300;
  localparam int CLK_KHZ = 25000;
  localparam int NVM_RC_DIV = (CLK_KHZ * NVM_WRITE_TYP_US) / (NVM_WRITE_RC_DEFAULT * 1000);
  typedef enum logic [2:0] {AM_DIRECT, AM_DISP, AM_INDIRECT, AM_PREDEC, AM_POSTINC}
    dma_addr_mode_t;
  typedef enum logic [2:0] {RG_REGFILE, RG_STD_IO, RG_EXT_IO, RG_INT_SRAM, RG_EXT_SRAM}
    dma_region_t;
  typedef enum logic [1:0] {ST_IDLE, ST_INT, ST_ALE, ST_STRB} dma_acc_state_t;
  typedef struct packed {
    logic valid;
    logic we;
    logic retAddr;
    logic ioShort;
    dma_addr_mode_t mode;
    logic [15:0] ptr;
    logic [5:0] disp;
    logic [7:0] wdata;
  } dma_req_t;
  typedef struct packed {
    logic extSramEnable;
    logic [1:0] waitStates;
  } dma_ext_mem_control_a_t;
  typedef struct packed {
    logic valid;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dma_acc_t;
  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } dma_ptr_wb_t;
  typedef struct packed {
    logic nvmReadStrobe;
    logic nvmWriteStrobe;
    logic nvmMasterWriteEnable;
  } dma_nvm_control_reg_t;
endpackage

// ==== dma_addr_gen.sv ====
// effective address and pointer update for one data access
`timescale 1ns/100ps
module dma_addr_gen (
  input dma_pkg::dma_req_t req,
  output logic [15:0] effAddr,
  output logic [15:0] ptrNext
);
  import dma_pkg::*;
  always_comb begin
    effAddr = req.ptr;
    ptrNext = req.ptr;
    case (req.mode)
      AM_DISP: effAddr = req.ptr + {10'h000, req.disp};
      AM_PREDEC: begin
        effAddr = req.ptr - 16'h0001;
        ptrNext = req.ptr - 16'h0001;
      end
      AM_POSTINC: ptrNext = req.ptr + 16'h0001;
      default: effAddr = req.ptr;
    endcase
    // short I/O opcodes carry six bits, so they can never reach extended I/O
    if (req.ioShort) begin
      effAddr = IO_SHORT_OFFSET + {10'h000, req.ptr[5:0]};
    end
  end
endmodule

// ==== dma_nvm.sv ====
// nonvolatile byte space: registers, halt timing and self-timed write
`timescale 1ns/100ps
module dma_nvm #(
  parameter int WRITE_RC_CYCLES = 26368
) (
  input logic clk,
  input logic nrst,
  input logic porN,
  input logic ctrlWr,
  input dma_pkg::dma_nvm_control_reg_t ctrlIn,
  input logic addrWr,
  input logic [11:0] addrIn,
  input logic dataWr,
  input logic [7:0] dataIn,
  output logic [11:0] addrR,
  output logic [7:0] dataR,
  output dma_pkg::dma_nvm_control_reg_t ctrlR,
  output logic haltR
);
  import dma_pkg::*;
  logic [7:0] mem [NVM_DEPTH];
  logic masterR;
  logic [2:0] winR;
  logic [2:0] haltCnt;
  logic busyR;
  logic [15:0] rcCnt;
  logic [1:0] divCnt;
  logic [11:0] wrAddr;
  logic [7:0] wrData;
  logic rcTick;
  logic startWr;
  logic startRd;
  logic wrDone;
  assign rcTick = divCnt == 2'(NVM_RC_DIV - 1);
  assign startWr = ctrlWr && ctrlIn.nvmWriteStrobe && masterR && !busyR;
  assign startRd = ctrlWr && ctrlIn.nvmReadStrobe && !ctrlIn.nvmWriteStrobe && !busyR;
  assign wrDone = busyR && rcTick && rcCnt == 16'(WRITE_RC_CYCLES - 1);
  assign ctrlR = '{nvmReadStrobe: 1'b0, nvmWriteStrobe: busyR, nvmMasterWriteEnable: masterR};
  // ----------------------------------------
  // registers seen by software
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addrR <= 12'h000;
      dataR <= 8'h00;
    end else begin
      if (addrWr && !busyR) begin
        addrR <= addrIn;
      end
      if (startRd) begin
        dataR <= mem[addrR];
      end else if (dataWr && !busyR) begin
        dataR <= dataIn;
      end
    end
  end
  // master enable only opens a short window, so a stray write strobe does nothing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      masterR <= 1'b0;
      winR <= 3'h0;
    end else if (ctrlWr && ctrlIn.nvmMasterWriteEnable && !ctrlIn.nvmWriteStrobe) begin
      masterR <= 1'b1;
      winR <= NVM_MASTER_WINDOW;
    end else if (startWr || winR == 3'h1) begin
      masterR <= 1'b0;
      winR <= 3'h0;
    end else if (winR != 3'h0) begin
      winR <= winR - 3'h1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      haltR <= 1'b0;
      haltCnt <= 3'h0;
    end else if (startRd) begin
      haltR <= 1'b1;
      haltCnt <= NVM_READ_HALT;
    end else if (startWr) begin
      haltR <= 1'b1;
      haltCnt <= NVM_WRITE_HALT;
    end else if (haltCnt != 3'h0) begin
      haltR <= haltCnt != 3'h1;
      haltCnt <= haltCnt - 3'h1;
    end
  end
  // ----------------------------------------
  // write engine, cleared only at power-on
  // ----------------------------------------
  always_ff @(posedge clk or negedge porN) begin
    if (!porN) begin
      busyR <= 1'b0;
      rcCnt <= 16'h0000;
      divCnt <= 2'h0;
      wrAddr <= 12'h000;
      wrData <= 8'h00;
    end else begin
      divCnt <= rcTick ? 2'h0 : divCnt + 2'h1;
      if (startWr) begin
        busyR <= 1'b1;
        rcCnt <= 16'h0000;
        wrAddr <= addrR;
        wrData <= dataR;
      end else if (wrDone) begin
        busyR <= 1'b0;
      end else if (busyR && rcTick) begin
        rcCnt <= rcCnt + 16'h0001;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (wrDone) begin
      mem[wrAddr] <= wrData;
    end
  end
  a_read_halt: assert property (@(posedge clk) disable iff (!nrst)
    startRd |=> haltR [*4] ##1 !haltR) else $error("read halt not four cycles");
  a_write_halt: assert property (@(posedge clk) disable iff (!nrst)
    startWr |=> haltR [*2] ##1 !haltR) else $error("write halt not two cycles");
  a_busy_hold: assert property (@(posedge clk) disable iff (!porN)
    startWr |=> ctrlR.nvmWriteStrobe [*8]) else $error("busy dropped early");
  a_read_data: assert property (@(posedge clk) disable iff (!nrst)
    startRd |=> dataR == mem[$past(addrR)]) else $error("read data wrong");
endmodule

// ==== dma_data_memory_access.sv ====
// data-space access: decode, internal SRAM, external bus and nonvolatile space
`timescale 1ns/100ps
module dma_data_memory_access #(
  parameter int NVM_WRITE_RC_CYCLES = 26368
) (
  input logic clk,
  input logic nrst,
  input logic nvmPorN,
  input dma_pkg::dma_req_t cpuReq,
  input dma_pkg::dma_ext_mem_control_a_t extMemControlA,
  input logic [7:0] coreRdata,
  output dma_pkg::dma_acc_t coreAcc,
  output dma_pkg::dma_ptr_wb_t ptrWb,
  output logic accAck,
  output logic accBusy,
  output logic rdValid,
  output logic [7:0] rdData,
  input logic [7:0] muxedAddrDataBusIn,
  output logic [7:0] muxedAddrDataBusOut,
  output logic muxedAddrDataBusOe,
  output logic [7:0] addrHigh,
  output logic addrLatchEnable,
  output logic extReadStrobePinN,
  output logic extWriteStrobePinN,
  input logic nvmCtrlWr,
  input dma_pkg::dma_nvm_control_reg_t nvmCtrlIn,
  input logic nvmAddrWr,
  input logic [11:0] nvmAddrIn,
  input logic nvmDataWr,
  input logic [7:0] nvmDataIn,
  output logic [11:0] nvmAddressReg,
  output logic [7:0] nvmDataReg,
  output dma_pkg::dma_nvm_control_reg_t nvmControlReg,
  output logic nvmHalt
);
  import dma_pkg::*;
  logic [7:0] sram [INT_SRAM_SIZE];
  logic [15:0] effAddr;
  logic [15:0] ptrNext;
  dma_region_t rgn;
  dma_region_t rgnR;
  dma_acc_state_t stateR;
  logic [3:0] cntR;
  logic [3:0] extraCyc;
  logic [15:0] addrR;
  logic weR;
  logic [7:0] wdR;
  logic [12:0] sramIdx;
  logic [7:0] syncA;
  logic [7:0] syncB;
  logic [1:0] rdPipe;
  logic take;
  logic goExt;
  logic endAcc;
  logic extEnd;
  // ----------------------------------------
  // address forming and decode
  // ----------------------------------------
  dma_addr_gen uAddrGen (
    .req(cpuReq),
    .effAddr(effAddr),
    .ptrNext(ptrNext)
  );
  always_comb begin
    if (effAddr < STD_IO_BASE) begin
      rgn = RG_REGFILE;
    end else if (effAddr < EXT_IO_BASE) begin
      rgn = RG_STD_IO;
    end else if (effAddr < INT_SRAM_BASE) begin
      rgn = RG_EXT_IO;
    end else if (effAddr < EXT_SRAM_BASE) begin
      rgn = RG_INT_SRAM;
    end else begin
      rgn = RG_EXT_SRAM;
    end
  end
  // a new request waits until the external read data has left the pipe
  assign take = cpuReq.valid && stateR == ST_IDLE && rdPipe == 2'h0;
  assign goExt = rgn == RG_EXT_SRAM && extMemControlA.extSramEnable;
  always_comb begin
    if (cpuReq.retAddr) begin
      extraCyc = 4'(RET_EXTRA_BASE + RET_EXTRA_PER_WS * extMemControlA.waitStates);
    end else begin
      extraCyc = 4'(EXT_BYTE_EXTRA + extMemControlA.waitStates);
    end
  end
  assign endAcc = stateR == ST_INT || (stateR == ST_STRB && cntR == 4'h1);
  assign extEnd = stateR == ST_STRB && cntR == 4'h1;
  assign sramIdx = 13'(addrR - INT_SRAM_BASE);
  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stateR <= ST_IDLE;
      cntR <= 4'h0;
    end else begin
      case (stateR)
        ST_IDLE: begin
          if (take && goExt) begin
            stateR <= ST_ALE;
            cntR <= extraCyc;
          end else if (take) begin
            stateR <= ST_INT;
          end
        end
        ST_INT: stateR <= ST_IDLE;
        ST_ALE: stateR <= ST_STRB;
        ST_STRB: begin
          cntR <= cntR - 4'h1;
          if (cntR == 4'h1) begin
            stateR <= ST_IDLE;
          end
        end
        default: stateR <= ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addrR <= 16'h0000;
      weR <= 1'b0;
      wdR <= 8'h00;
      rgnR <= RG_REGFILE;
    end else if (take) begin
      addrR <= effAddr;
      weR <= cpuReq.we;
      wdR <= cpuReq.wdata;
      rgnR <= rgn;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      accAck <= 1'b0;
      accBusy <= 1'b0;
    end else begin
      accAck <= endAcc;
      accBusy <= take || (stateR != ST_IDLE && !endAcc) || (extEnd && !weR) || rdPipe[0];
    end
  end
  // register file and I/O live in the core; they see one request pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      coreAcc <= '0;
      ptrWb <= '0;
    end else begin
      coreAcc.valid <= take && rgn != RG_INT_SRAM && rgn != RG_EXT_SRAM;
      coreAcc.we <= cpuReq.we;
      coreAcc.addr <= effAddr;
      coreAcc.wdata <= cpuReq.wdata;
      ptrWb.valid <= take && (cpuReq.mode == AM_PREDEC || cpuReq.mode == AM_POSTINC);
      ptrWb.value <= ptrNext;
    end
  end
  // ----------------------------------------
  // internal SRAM and read data
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (stateR == ST_INT && rgnR == RG_INT_SRAM && weR) begin
      sram[sramIdx] <= wdR;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= 8'h00;
      rdValid <= 1'b0;
      rdPipe <= 2'h0;
    end else begin
      rdPipe <= {rdPipe[0], extEnd && !weR};
      rdValid <= (stateR == ST_INT && !weR) || rdPipe[1];
      if (rdPipe[1]) begin
        rdData <= syncB;
      end else if (stateR == ST_INT && rgnR == RG_INT_SRAM) begin
        rdData <= sram[sramIdx];
      end else if (stateR == ST_INT && rgnR == RG_EXT_SRAM) begin
        rdData <= 8'h00;
      end else if (stateR == ST_INT) begin
        rdData <= coreRdata;
      end
    end
  end
  // ----------------------------------------
  // external bus pins
  // ----------------------------------------
  // the pin data is two flops late, so external read data follows the ack
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syncA <= 8'h00;
      syncB <= 8'h00;
    end else begin
      syncA <= muxedAddrDataBusIn;
      syncB <= syncA;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addrLatchEnable <= 1'b0;
      muxedAddrDataBusOut <= 8'h00;
      muxedAddrDataBusOe <= 1'b0;
      addrHigh <= 8'h00;
      extReadStrobePinN <= 1'b1;
      extWriteStrobePinN <= 1'b1;
    end else if (take && goExt) begin
      addrLatchEnable <= 1'b1;
      muxedAddrDataBusOut <= effAddr[7:0];
      muxedAddrDataBusOe <= 1'b1;
      addrHigh <= effAddr[15:8];
    end else if (stateR == ST_ALE) begin
      addrLatchEnable <= 1'b0;
      muxedAddrDataBusOut <= wdR;
      muxedAddrDataBusOe <= weR;
      extWriteStrobePinN <= !weR;
      extReadStrobePinN <= weR;
    end else if (extEnd) begin
      muxedAddrDataBusOe <= 1'b0;
      extWriteStrobePinN <= 1'b1;
      extReadStrobePinN <= 1'b1;
    end
  end
  // ----------------------------------------
  // nonvolatile byte space
  // ----------------------------------------
  dma_nvm #(
    .WRITE_RC_CYCLES(NVM_WRITE_RC_CYCLES)
  ) uNvm (
    .clk(clk),
    .nrst(nrst),
    .porN(nvmPorN),
    .ctrlWr(nvmCtrlWr),
    .ctrlIn(nvmCtrlIn),
    .addrWr(nvmAddrWr),
    .addrIn(nvmAddrIn),
    .dataWr(nvmDataWr),
    .dataIn(nvmDataIn),
    .addrR(nvmAddressReg),
    .dataR(nvmDataReg),
    .ctrlR(nvmControlReg),
    .haltR(nvmHalt)
  );
  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic takeInt;
  logic takePlain;
  logic takeRet;
  assign takeInt = take && !goExt;
  assign takePlain = take && goExt && !cpuReq.retAddr;
  assign takeRet = take && goExt && cpuReq.retAddr;
  sequence s_noAck2;
    !accAck [*2];
  endsequence
  sequence s_noAck5;
    !accAck [*5];
  endsequence
  a_int_time: assert property (@(posedge clk) disable iff (!nrst)
    takeInt |-> ##1 !accAck ##1 accAck) else $error("internal access not two cycles");
  a_int_strobes: assert property (@(posedge clk) disable iff (!nrst)
    takeInt |-> (extReadStrobePinN && extWriteStrobePinN) [*3])
    else $error("strobe during internal access");
  a_ext_gate: assert property (@(posedge clk) disable iff (!nrst)
    take && rgn == RG_EXT_SRAM && !extMemControlA.extSramEnable
      |-> ##1 (!addrLatchEnable && extReadStrobePinN && extWriteStrobePinN) [*2])
    else $error("external access while disabled");
  a_ext_start: assert property (@(posedge clk) disable iff (!nrst)
    take && effAddr >= EXT_SRAM_BASE && extMemControlA.extSramEnable |=> addrLatchEnable)
    else $error("external region not routed out");
  a_byte_ws0: assert property (@(posedge clk) disable iff (!nrst)
    takePlain && extMemControlA.waitStates == 2'h0 |-> ##1 s_noAck2 ##1 accAck)
    else $error("external byte not one extra cycle");
  a_byte_ws3: assert property (@(posedge clk) disable iff (!nrst)
    takePlain && extMemControlA.waitStates == 2'h3 |-> ##1 s_noAck5 ##1 accAck)
    else $error("three wait-states not four extra");
  a_ret_ws0: assert property (@(posedge clk) disable iff (!nrst)
    takeRet && extMemControlA.waitStates == 2'h0 |-> ##1 !accAck [*4] ##1 accAck)
    else $error("external stack not three extra");
  a_ret_ws1: assert property (@(posedge clk) disable iff (!nrst)
    takeRet && extMemControlA.waitStates == 2'h1 |-> ##1 !accAck [*6] ##1 accAck)
    else $error("external stack wait not five extra");
  a_ale_data: assert property (@(posedge clk) disable iff (!nrst)
    !extReadStrobePinN || !extWriteStrobePinN |-> !addrLatchEnable)
    else $error("latch enable high during data");
  a_io_short: assert property (@(posedge clk) disable iff (!nrst)
    take && cpuReq.ioShort |=> coreAcc.valid && coreAcc.addr < EXT_IO_BASE)
    else $error("short I/O reached extended I/O");
  a_disp_addr: assert property (@(posedge clk) disable iff (!nrst)
    take && cpuReq.mode == AM_DISP && !cpuReq.ioShort
      |=> addrR == $past(cpuReq.ptr) + {10'h000, $past(cpuReq.disp)})
    else $error("displacement address wrong");
  a_post_inc: assert property (@(posedge clk) disable iff (!nrst)
    take && cpuReq.mode == AM_POSTINC
      |=> ptrWb.valid && ptrWb.value == $past(cpuReq.ptr) + 16'h0001)
    else $error("post-increment wrong");
endmodule

// ==== dma_ext_sram_model.sv ====
// behavioural external SRAM behind the multiplexed address/data bus
`timescale 1ns/100ps
module dma_ext_sram_model (
  input logic clk,
  input logic [7:0] busOut,
  input logic [7:0] addrHigh,
  input logic ale,
  input logic rdN,
  input logic wrN,
  output logic [7:0] busIn
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr = 16'h0000;
  logic [7:0] last = 8'h00;
  // ----------------------------------------
  // bus capture
  // ----------------------------------------
  // latch is transparent while ale is high, so the last high cycle holds the address
  always @(posedge clk) begin
    if (ale) addr <= {addrHigh, busOut};
    if (!wrN) mem[addr] <= busOut;
    if (!rdN) last <= mem[addr];
  end
  // released bus shows the inverse of the last byte so a stale value never matches
  assign busIn = rdN ? ~last : mem[addr];
endmodule

// ==== data_memory_access_test.sv ====
// self-checking bench for the data memory access block
`timescale 1ns/100ps
module data_memory_access_test;
  import dma_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int RC = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic por = 1'b0;
  dma_req_t req;
  dma_ext_mem_control_a_t xm;
  dma_acc_t cacc;
  dma_ptr_wb_t wb;
  dma_nvm_control_reg_t nci, ncr;
  logic ack, busy, rdv, ale, rdN, wrN, oe, halt, ncw, naw, ndw;
  logic [7:0] crd, rdd, bin, bout, ah, ndr, ndi, rd;
  logic [11:0] nar, nai;
  logic [15:0] aleAddr, ca, pw;
  int miscompares = 0;
  int checked = 0;
  int n, h;
  dma_data_memory_access #(.NVM_WRITE_RC_CYCLES(RC)) uut (
    .clk(clk), .nrst(nrst), .nvmPorN(por), .cpuReq(req), .extMemControlA(xm),
    .coreRdata(crd), .coreAcc(cacc), .ptrWb(wb), .accAck(ack), .accBusy(busy),
    .rdValid(rdv), .rdData(rdd), .muxedAddrDataBusIn(bin), .muxedAddrDataBusOut(bout),
    .muxedAddrDataBusOe(oe), .addrHigh(ah), .addrLatchEnable(ale),
    .extReadStrobePinN(rdN), .extWriteStrobePinN(wrN), .nvmCtrlWr(ncw), .nvmCtrlIn(nci),
    .nvmAddrWr(naw), .nvmAddrIn(nai), .nvmDataWr(ndw), .nvmDataIn(ndi),
    .nvmAddressReg(nar), .nvmDataReg(ndr), .nvmControlReg(ncr), .nvmHalt(halt));
  dma_ext_sram_model ext (.clk(clk), .busOut(bout), .addrHigh(ah), .ale(ale), .rdN(rdN),
    .wrN(wrN), .busIn(bin));
  initial begin
    forever #20 clk = ~clk;
  end
  always @(negedge clk) begin
    if (ale) aleAddr = {ah, bout};
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    checked++;
    if (got != exp) begin
      miscompares++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  // one access; request held until ack is seen, q marks accesses that must keep strobes idle
  task automatic acc(input logic we, ra, io, input dma_addr_mode_t m, input logic [15:0] p,
                     input logic [5:0] d, input logic [7:0] w, input logic q);
    int k;
    logic got;
    @(negedge clk);
    req = '{1'b1, we, ra, io, m, p, d, w};
    {n, got, rd, ca, pw} = {32'h0, 1'b0, 8'hXX, 16'hFFFF, 16'hFFFF};
    for (k = 1; k < 40 && !(n > 0 && (we || got)); k++) begin
      @(negedge clk);
      if (q) chkv({14'h0, rdN, wrN}, 16'h0003);
      if (!(rdN && wrN)) chkv({15'h0, ale}, 16'h0000);
      if (!wrN) chkv({15'h0, oe}, 16'h0001);
      if (!rdN) chkv({15'h0, oe}, 16'h0000);
      if (k == 1) chkv({15'h0, busy}, 16'h0001);
      if (cacc.valid === 1'b1) ca = cacc.addr;
      if (wb.valid === 1'b1) pw = wb.value;
      if (rdv === 1'b1) {got, rd} = {1'b1, rdd};
      if (ack === 1'b1 && n == 0) begin
        n = k;
        req.valid = 1'b0;
      end
    end
    if (n == 0 || !(we || got)) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic nreg(input logic [11:0] a, input logic [7:0] dv);
    @(negedge clk);
    {naw, ndw, nai, ndi} = {2'b11, a, dv};
    @(negedge clk);
    {naw, ndw} = 2'b00;
  endtask
  // control write; counts the cycles the core is halted
  task automatic nvm(input logic [2:0] c);
    @(negedge clk);
    {ncw, nci} = {1'b1, c};
    @(negedge clk);
    ncw = 1'b0;
    h = 0;
    while (halt === 1'b1 && h < 10) begin
      h++;
      @(negedge clk);
    end
  endtask
  task automatic nwait;
    n = 0;
    while (ncr.nvmWriteStrobe !== 1'b0 && n < 200) begin
      n++;
      @(negedge clk);
    end
    if (n == 200) begin
      miscompares++;
      close_out();
    end
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {req, xm, nci, ncw, naw, ndw, nai, ndi} = '0;
    crd = 8'h3C;
    repeat (4) @(negedge clk);
    {nrst, por} = 2'b11;
    acc(0, 0, 0, AM_DIRECT, 16'h2200, 0, 0, 1);
    chkn(n, 2);
    chkv(rd, 16'h0000);
    xm.extSramEnable = 1'b1;
    acc(0, 0, 0, AM_DIRECT, 16'h001F, 0, 0, 1);
    chkn(n, 2);
    chkv(ca, 16'h001F);
    chkv(rd, 16'h003C);
    acc(0, 0, 1, AM_DIRECT, 16'h0005, 0, 0, 1);
    chkv(ca, 16'h0025);
    acc(1, 0, 0, AM_DIRECT, 16'h0060, 0, 8'h11, 1);
    chkv(ca, 16'h0060);
    acc(1, 0, 0, AM_DISP, 16'h0300, 6'h3F, 8'h55, 1);
    chkn(n, 2);
    acc(0, 0, 0, AM_PREDEC, 16'h0340, 0, 0, 1);
    chkv(rd, 16'h0055);
    chkv(pw, 16'h033F);
    acc(0, 0, 0, AM_POSTINC, 16'h033F, 0, 0, 1);
    chkv(pw, 16'h0340);
    acc(1, 0, 0, AM_DIRECT, 16'h21FF, 0, 8'h77, 1);
    chkv(ca, 16'hFFFF);
    acc(0, 0, 0, AM_DIRECT, 16'h21FF, 0, 0, 1);
    chkv(rd, 16'h0077);
    for (int ws = 0; ws < 4; ws++) begin
      xm.waitStates = ws[1:0];
      acc(1, 0, 0, AM_DIRECT, 16'h2200 + 16'(ws), 0, 8'hA0 + 8'(ws), 0);
      chkn(n, 3 + ws);
      chkv(aleAddr, 16'h2200 + 16'(ws));
      chkv(ext.mem[16'h2200 + 16'(ws)], 16'h00A0 + 16'(ws));
      acc(0, 0, 0, AM_DIRECT, 16'h2200 + 16'(ws), 0, 0, 0);
      chkn(n, 3 + ws);
      chkv(rd, 16'h00A0 + 16'(ws));
      acc(1, 1, 0, AM_DIRECT, 16'hFF00 + 16'(ws), 0, 8'h5C, 0);
      chkn(n, 5 + 2 * ws);
    end
    nreg(12'hFFF, 8'h5A);
    chkv(16'(nar), 16'h0FFF);
    nvm(3'b010);
    chkv({15'h0, ncr.nvmWriteStrobe}, 16'h0000);
    nwait();
    nvm(3'b001);
    nvm(3'b010);
    chkn(h, 2);
    chkv({15'h0, ncr.nvmWriteStrobe}, 16'h0001);
    nwait();
    chkn(int'(n >= RC * 3 - 5 && n <= RC * 3), 1);
    nvm(3'b100);
    chkn(h, 4);
    chkv(16'(ndr), 16'h005A);
    nreg(12'h001, 8'hC3);
    nvm(3'b001);
    nvm(3'b010);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    chkv({15'h0, ncr.nvmWriteStrobe}, 16'h0001);
    nwait();
    nreg(12'h001, 8'h00);
    nvm(3'b100);
    chkv(16'(ndr), 16'h00C3);
    close_out();
  end
endmodule
